// file: src/cpv_pkg.sv
package cpv_pkg;

    // ---------------------------------------------------------------
    // Clock and timing
    // ---------------------------------------------------------------
    localparam int CLK_HZ = 40_000_000;
    localparam int DEBOUNCE_MS = 40;          // Request glitch filter, typical
    localparam int UNPLUG_MS = 500;           // Longest return to default
    localparam int DIS_HOLD_MS = 20;          // Discharge tail after feedback drop
    localparam int STEP_US = 1000;            // Time between setpoint steps
    localparam int DEBOUNCE_CYC = (CLK_HZ / 1000) * DEBOUNCE_MS;
    localparam int DIS_HOLD_CYC = (CLK_HZ / 1000) * DIS_HOLD_MS;
    localparam int STEP_CYC = (CLK_HZ / 1_000_000) * STEP_US;
    localparam int CNT_W = 24;

    // ---------------------------------------------------------------
    // Setpoint codes, 100 mV per unit
    // ---------------------------------------------------------------
    localparam int SP_W = 8;
    localparam logic [SP_W-1:0] SP_DEF = 8'h33;   // 5.1 V
    localparam logic [SP_W-1:0] SP_9V = 8'h5A;    // 9.0 V
    localparam logic [SP_W-1:0] SP_12V = 8'h78;   // 12.0 V
    localparam logic [SP_W-1:0] SP_MIN = 8'h24;   // 3.6 V
    localparam logic [SP_W-1:0] SP_STEP = 8'h02;  // 200 mV
    localparam logic [SP_W-1:0] OVP_REC = 8'h37;  // 5.5 V
    localparam logic [15:0] OVP_PCT = 16'h0073;   // 115 percent
    localparam logic [15:0] PCT_DIV = 16'h0064;   // 100 percent
    localparam logic [7:0] TEMP_SHUT = 8'hA0;     // 160 C
    localparam logic [7:0] TEMP_RESUME = 8'h7D;   // 125 C

    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        REQ_NONE, REQ_5V, REQ_9V, REQ_12V, REQ_CONT, REQ_HOLD
    } cpv_req_e;

    typedef enum logic [1:0] {ST_OFF, ST_RUN, ST_OVP} cpv_state_e;

    // Data line comparator levels
    typedef struct packed {
        logic dp_present;   // D+ above 0.6 V class
        logic dp_hi;        // D+ at 3.3 V class
        logic dm_hi;        // D- at 3.3 V class
        logic dm_gnd;       // D- grounded
    } cpv_line_s;

    // Analog sense readings
    typedef struct packed {
        logic [SP_W-1:0] vin_code;      // Input voltage, 100 mV units
        logic [7:0] temp_code;          // Die temperature, degrees C
        logic converter_feedback_node;  // Feedback above 108 % of reference
        logic supply_ok;                // Supply above start threshold
    } cpv_sense_s;

    // ---------------------------------------------------------------
    // Line state decoding
    // ---------------------------------------------------------------
    function automatic cpv_req_e cpv_decode(input cpv_line_s ln);
        logic dp_mid;
        logic dm_mid;
        dp_mid = ln.dp_present && !ln.dp_hi;
        dm_mid = !ln.dm_hi && !ln.dm_gnd;
        if (!ln.dp_present) begin
            cpv_decode = REQ_NONE;
        end else if (dp_mid && dm_mid) begin
            cpv_decode = REQ_12V;
        end else if (ln.dp_hi && dm_mid) begin
            cpv_decode = REQ_9V;
        end else if (dp_mid && ln.dm_hi) begin
            cpv_decode = REQ_CONT;
        end else if (ln.dp_hi && ln.dm_hi) begin
            cpv_decode = REQ_HOLD;
        end else if (dp_mid && ln.dm_gnd) begin
            cpv_decode = REQ_5V;
        end else begin
            cpv_decode = REQ_NONE;
        end
    endfunction

endpackage

// file: src/cpv_line_qual.sv
`timescale 1ns/1ps
module cpv_line_qual #(
    parameter int DEB_CYC = cpv_pkg::DEBOUNCE_CYC
) (
    input wire logic i_clk_sys,               // System clock
    input wire logic i_rst_n,                 // Async reset, active low
    input cpv_pkg::cpv_line_s i_line,         // Data line levels
    output cpv_pkg::cpv_req_e o_req,          // Accepted request
    output logic o_req_valid                  // Pulse on new request
);
    import cpv_pkg::*;

    typedef struct packed {
        cpv_req_e cand;
        cpv_req_e acc;
        logic [CNT_W-1:0] cnt;
        logic valid;
    } cpv_qual_s;

    cpv_qual_s cur_ff;
    cpv_qual_s nxt_q;
    cpv_req_e dec;

    // ---------------------------------------------------------------
    // Debounce of decoded line state
    // ---------------------------------------------------------------
    always_comb begin
        dec = cpv_decode(i_line);
        nxt_q = cur_ff;
        nxt_q.valid = 1'b0;
        if (dec != cur_ff.cand) begin
            nxt_q.cand = dec;
            nxt_q.cnt = '0;
        end else if (cur_ff.cnt != CNT_W'(DEB_CYC - 1)) begin
            nxt_q.cnt = cur_ff.cnt + CNT_W'(1);
        end else if (cur_ff.cand != cur_ff.acc && cur_ff.cand != REQ_NONE) begin
            nxt_q.acc = cur_ff.cand;
            nxt_q.valid = 1'b1;
        end
        // Removal clears memory so a replug re-requests
        if (!i_line.dp_present) begin
            nxt_q.acc = REQ_NONE;
        end
    end

    // State register
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cur_ff <= '{cand: REQ_NONE, acc: REQ_NONE, cnt: '0, valid: 1'b0};
        end else begin
            cur_ff <= nxt_q;
        end
    end

    assign o_req = cur_ff.acc;
    assign o_req_valid = cur_ff.valid;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    sequence line_settled_s;
        cur_ff.cnt == CNT_W'(DEB_CYC - 1) && dec == cur_ff.cand;
    endsequence

    debounce_wait_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        o_req_valid |-> $past(cur_ff.cnt) == CNT_W'(DEB_CYC - 1))
        else $error("request accepted before debounce expired");

    debounce_take_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (line_settled_s and (cur_ff.cand != cur_ff.acc) and (cur_ff.cand != REQ_NONE)
         and i_line.dp_present) |=> o_req_valid && o_req == $past(cur_ff.cand))
        else $error("settled request not accepted");

endmodule

// file: src/cpv_port_ctrl.sv
`timescale 1ns/1ps
// How it works
// - Line levels map to 12V, 9V, continuous, hold or 5V requests.
// - Continuous mode steps the setpoint 200mV at a time within 3.6V to 12V.
// - A new line state must stay stable for the debounce time first.
// - D+ dropping below 0.6V returns the request to default 5V quickly.
// - Adjust output runs once supply is above start threshold, aiming 5.1V.
// - In default mode at the 5.1V setpoint, adjustment stops while input already exceeds 5.1V.
// - Input above overvoltage threshold turns discharge on; exit below 5.5V.
// - Overvoltage threshold is 115 percent of setpoint; recovery resets to 5V.
// - Discharge stays on when lowering, off 20ms after feedback drops.
// - Shut down above 160C, resume below 125C.
// - Enable high or pulled up runs the block, low disables it.
module cpv_port_ctrl #(
    parameter int DEB_CYC = cpv_pkg::DEBOUNCE_CYC,
    parameter int STEP_CYC = cpv_pkg::STEP_CYC,
    parameter int DIS_CYC = cpv_pkg::DIS_HOLD_CYC
) (
    input wire logic i_clk_sys,                         // System clock, 40 MHz
    input wire logic i_rst_n,                           // Async reset, active low
    input wire logic i_en,                              // Enable, high or pulled up
    input cpv_pkg::cpv_line_s i_line,                   // Data line levels
    input cpv_pkg::cpv_sense_s i_sense,                 // Analog sense readings
    input wire logic i_cont_inc,                        // Continuous step up pulse
    input wire logic i_cont_dec,                        // Continuous step down pulse
    output logic [cpv_pkg::SP_W-1:0] o_setpoint_sink_output, // Setpoint code
    output logic o_sink_active,                         // Adjust sink running
    output logic o_input_overvoltage_guard,             // Input discharge on
    output logic o_shutdown,                            // Block is off
    output cpv_pkg::cpv_req_e o_mode                    // Active request mode
);
    import cpv_pkg::*;

    typedef struct packed {
        cpv_state_e state;
        cpv_req_e mode;
        logic [SP_W-1:0] setpoint;
        logic [SP_W-1:0] target;
        logic [CNT_W-1:0] step_cnt;
        logic [CNT_W-1:0] dis_cnt;
        logic down;
        logic hot;
        logic sink;
        logic guard;
        logic shut;
    } cpv_ctrl_s;

    cpv_ctrl_s cur_ff;
    cpv_ctrl_s nxt_c;
    cpv_req_e req;
    logic req_valid;
    logic off;
    logic tick;
    logic [15:0] ovp_prod;
    logic [SP_W-1:0] ovp_th;
    logic [SP_W-1:0] diff;

    // ---------------------------------------------------------------
    // Request qualifier
    // ---------------------------------------------------------------
    cpv_line_qual #(
        .DEB_CYC(DEB_CYC)
    ) u_qual (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_line(i_line),
        .o_req(req),
        .o_req_valid(req_valid)
    );

    // Dynamic overvoltage threshold
    assign ovp_prod = (16'(cur_ff.setpoint) * OVP_PCT) / PCT_DIV;
    assign ovp_th = ovp_prod[SP_W-1:0];

    // ---------------------------------------------------------------
    // Control state machine
    // ---------------------------------------------------------------
    always_comb begin
        nxt_c = cur_ff;
        diff = '0;
        // Thermal hysteresis
        if (i_sense.temp_code > TEMP_SHUT) begin
            nxt_c.hot = 1'b1;
        end else if (i_sense.temp_code < TEMP_RESUME) begin
            nxt_c.hot = 1'b0;
        end
        off = !i_en || !i_sense.supply_ok || nxt_c.hot;
        tick = cur_ff.step_cnt == CNT_W'(STEP_CYC - 1);
        nxt_c.step_cnt = tick ? '0 : cur_ff.step_cnt + CNT_W'(1);
        case (cur_ff.state)
            ST_OFF: begin
                nxt_c.setpoint = SP_DEF;
                nxt_c.target = SP_DEF;
                nxt_c.mode = REQ_5V;
                nxt_c.down = 1'b0;
                nxt_c.dis_cnt = '0;
                if (!off) begin
                    nxt_c.state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (off) begin
                    nxt_c.state = ST_OFF;
                end else if (i_sense.vin_code > ovp_th) begin
                    nxt_c.state = ST_OVP;
                end else begin
                    // New requests
                    if (!i_line.dp_present) begin
                        nxt_c.mode = REQ_5V;
                        nxt_c.target = SP_DEF;
                    end else if (req_valid) begin
                        case (req)
                            REQ_5V: begin
                                nxt_c.mode = REQ_5V;
                                nxt_c.target = SP_DEF;
                            end
                            REQ_9V: begin
                                nxt_c.mode = REQ_9V;
                                nxt_c.target = SP_9V;
                            end
                            REQ_12V: begin
                                nxt_c.mode = REQ_12V;
                                nxt_c.target = SP_12V;
                            end
                            REQ_CONT: begin
                                nxt_c.mode = REQ_CONT;
                                nxt_c.target = cur_ff.setpoint;
                            end
                            default: begin
                                nxt_c.mode = cur_ff.mode;
                            end
                        endcase
                    end else if (cur_ff.mode == REQ_CONT) begin
                        if (i_cont_inc && cur_ff.target <= SP_12V - SP_STEP) begin
                            nxt_c.target = cur_ff.target + SP_STEP;
                        end else if (i_cont_dec && cur_ff.target >= SP_MIN + SP_STEP) begin
                            nxt_c.target = cur_ff.target - SP_STEP;
                        end
                    end
                    // Lowering starts discharge
                    if (nxt_c.target < cur_ff.setpoint && nxt_c.target != cur_ff.target) begin
                        nxt_c.down = 1'b1;
                        nxt_c.dis_cnt = '0;
                    end else if (cur_ff.down && cur_ff.setpoint == cur_ff.target
                                 && !i_sense.converter_feedback_node) begin
                        nxt_c.dis_cnt = cur_ff.dis_cnt + CNT_W'(1);
                        if (cur_ff.dis_cnt == CNT_W'(DIS_CYC - 1)) begin
                            nxt_c.down = 1'b0;
                        end
                    end else begin
                        nxt_c.dis_cnt = '0;
                    end
                    // Walk setpoint one increment per tick
                    if (tick && cur_ff.setpoint < cur_ff.target) begin
                        diff = cur_ff.target - cur_ff.setpoint;
                        nxt_c.setpoint = cur_ff.setpoint
                                         + ((diff > SP_STEP) ? SP_STEP : diff);
                    end else if (tick && cur_ff.setpoint > cur_ff.target) begin
                        diff = cur_ff.setpoint - cur_ff.target;
                        nxt_c.setpoint = cur_ff.setpoint
                                         - ((diff > SP_STEP) ? SP_STEP : diff);
                    end
                end
            end
            ST_OVP: begin
                if (off) begin
                    nxt_c.state = ST_OFF;
                end else if (i_sense.vin_code < OVP_REC) begin
                    nxt_c.state = ST_RUN;
                    nxt_c.mode = REQ_5V;
                    nxt_c.setpoint = SP_DEF;
                    nxt_c.target = SP_DEF;
                    nxt_c.down = 1'b0;
                    nxt_c.dis_cnt = '0;
                end
            end
            default: begin
                nxt_c.state = ST_OFF;
            end
        endcase
        // Registered outputs
        nxt_c.sink = nxt_c.state == ST_RUN
                     && !(nxt_c.mode == REQ_5V && nxt_c.setpoint == SP_DEF
                          && i_sense.vin_code > SP_DEF);
        nxt_c.guard = nxt_c.state == ST_OVP || nxt_c.down;
        nxt_c.shut = nxt_c.state == ST_OFF;
    end

    // State register
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cur_ff <= '{state: ST_OFF, mode: REQ_5V, setpoint: SP_DEF, target: SP_DEF,
                        step_cnt: '0, dis_cnt: '0, down: 1'b0, hot: 1'b0,
                        sink: 1'b0, guard: 1'b0, shut: 1'b1};
        end else begin
            cur_ff <= nxt_c;
        end
    end

    // Output drive
    assign o_setpoint_sink_output = cur_ff.setpoint;
    assign o_sink_active = cur_ff.sink;
    assign o_input_overvoltage_guard = cur_ff.guard;
    assign o_shutdown = cur_ff.shut;
    assign o_mode = cur_ff.mode;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    sequence ovp_recover_s;
        cur_ff.state == ST_OVP && !off && i_sense.vin_code < OVP_REC;
    endsequence

    sequence run_both_s;
        cur_ff.state == ST_RUN && $past(cur_ff.state) == ST_RUN;
    endsequence

    ovp_enter_a: assert property (
        (cur_ff.state == ST_RUN && !off && i_sense.vin_code > ovp_th)
        |=> cur_ff.state == ST_OVP && o_input_overvoltage_guard)
        else $error("overvoltage not entered");

    ovp_recover_a: assert property (
        ovp_recover_s |=> o_mode == REQ_5V && o_setpoint_sink_output == SP_DEF
                          && !o_input_overvoltage_guard)
        else $error("overvoltage recovery did not reset to default");

    thermal_off_a: assert property (
        i_sense.temp_code > TEMP_SHUT |=> o_shutdown && !o_sink_active)
        else $error("no shutdown on overtemperature");

    thermal_hold_a: assert property (
        cur_ff.hot && i_sense.temp_code >= TEMP_RESUME |=> cur_ff.hot)
        else $error("resumed above lower threshold");

    enable_off_a: assert property (
        !i_en |=> o_shutdown && !o_sink_active)
        else $error("block ran while disabled");

    step_size_a: assert property (
        run_both_s |-> (o_setpoint_sink_output >= $past(o_setpoint_sink_output)
            ? o_setpoint_sink_output - $past(o_setpoint_sink_output)
            : $past(o_setpoint_sink_output) - o_setpoint_sink_output) <= SP_STEP)
        else $error("setpoint moved more than one increment");

    setpoint_range_a: assert property (
        o_setpoint_sink_output >= SP_MIN && o_setpoint_sink_output <= SP_12V)
        else $error("setpoint out of range");

    unplug_default_a: assert property (
        (cur_ff.state == ST_RUN && !off && i_sense.vin_code <= ovp_th
         && !i_line.dp_present) |=> o_mode == REQ_5V && cur_ff.target == SP_DEF)
        else $error("removal did not restore default request");

    default_idle_a: assert property (
        (o_mode == REQ_5V && o_setpoint_sink_output == SP_DEF
         && i_sense.vin_code > SP_DEF) |-> !nxt_c.sink)
        else $error("adjusting above default level");

    down_discharge_a: assert property (
        (cur_ff.down && cur_ff.setpoint != cur_ff.target) |-> o_input_overvoltage_guard)
        else $error("discharge off during lowering");

endmodule

// file: tb/cpv_portable_dev.sv
`timescale 1ns/1ps
module cpv_portable_dev
    import cpv_pkg::*;
(
    input wire logic i_plug,             // Device attached to the port
    input cpv_pkg::cpv_req_e i_ask,      // Voltage the device asks for
    output cpv_pkg::cpv_line_s o_line    // Comparator levels seen by the port
);
    // ---------------------------------------------------------------
    // Line signalling
    // ---------------------------------------------------------------
    // Detached lines sit on the port pull-downs, so every level reads low
    always_comb begin
        o_line = '0;
        if (i_plug) begin
            case (i_ask)
                REQ_12V: o_line = 4'h8;
                REQ_9V: o_line = 4'hC;
                REQ_CONT: o_line = 4'hA;
                REQ_HOLD: o_line = 4'hE;
                default: o_line = 4'h9;
            endcase
        end
    end
endmodule

// file: tb/cpv_port_ctrl_test.sv
`timescale 1ns/1ps
module cpv_port_ctrl_test;
    import cpv_pkg::*;
    // ---------------------------------------------------------------
    // Short counts keep the run brief
    // ---------------------------------------------------------------
    localparam int DEB = 8;
    localparam int STP = 4;
    localparam int DIS = 6;
    logic i_clk_sys = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_en = 1'b1;
    logic plug = 1'b0;
    cpv_req_e ask = REQ_5V;
    cpv_line_s line;
    cpv_sense_s sense = {8'h30, 8'h19, 1'b0, 1'b1};
    logic inc = 1'b0;
    logic dec = 1'b0;
    logic up;
    logic [7:0] sp;
    logic [7:0] sp_prev;
    logic [7:0] exp_sp;
    logic sink;
    logic guard;
    logic shut;
    logic walk_on = 1'b0;
    cpv_req_e mode;
    int fails = 0;
    int n_checks = 0;
    int seed = 48;

    // Clock, 25 ns period
    always #12.5 i_clk_sys = ~i_clk_sys;

    cpv_port_ctrl #(.DEB_CYC(DEB), .STEP_CYC(STP), .DIS_CYC(DIS)) cpv_port_ctrl_i (
        .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_en(i_en), .i_line(line),
        .i_sense(sense), .i_cont_inc(inc), .i_cont_dec(dec),
        .o_setpoint_sink_output(sp), .o_sink_active(sink),
        .o_input_overvoltage_guard(guard), .o_shutdown(shut), .o_mode(mode));

    cpv_portable_dev cpv_portable_dev_i (.i_plug(plug), .i_ask(ask), .o_line(line));

    // ---------------------------------------------------------------
    // Compare and wait helpers
    // ---------------------------------------------------------------
    task automatic chk_sp(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_mode(input cpv_req_e got, input cpv_req_e exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge i_clk_sys);
    endtask

    // Bounded wait for the setpoint walk to land
    task automatic wait_sp(input logic [7:0] v);
        int k;
        k = 0;
        while (sp !== v && k < 2000) begin
            @(negedge i_clk_sys);
            k++;
        end
    endtask

    task automatic ask_for(input cpv_req_e r, input cpv_req_e m);
        plug = 1'b1;
        ask = r;
        tick(DEB + 4);
        chk_mode(mode, m);
    endtask

    // Continuous target after one pulse, held where a full step would leave the span
    function automatic logic [7:0] cont_next(input logic [7:0] t, input logic u);
        if (u) begin
            cont_next = (t <= SP_12V - SP_STEP) ? t + SP_STEP : t;
        end else begin
            cont_next = (t >= SP_MIN + SP_STEP) ? t - SP_STEP : t;
        end
    endfunction

    task automatic print_verdict;
        $display("checks=%0d fails=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ---------------------------------------------------------------
    // Monitors
    // ---------------------------------------------------------------
    // During walks the setpoint never moves more than one increment per change
    always @(posedge i_clk_sys) begin
        if (walk_on && (sp > sp_prev + 8'h02 || sp_prev > sp + 8'h02)) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, sp, sp_prev);
        end
        sp_prev <= sp;
    end

    // Watchdog on a hung sequence
    initial begin
        #1_000_000;
        fails++;
        print_verdict();
    end

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        tick(3);
        chk_sp(sp, SP_DEF);
        chk_bit(shut, 1'b1);
        i_rst_n = 1'b1;
        tick(3);
        chk_bit(shut, 1'b0);
        chk_bit(sink, 1'b1);
        sense.vin_code = 8'h34;
        tick(3);
        chk_bit(sink, 1'b0);
        sense.vin_code = 8'h20 + 8'($random(seed) & 15);
        tick(3);
        chk_bit(sink, 1'b1);
        sense.supply_ok = 1'b0;
        tick(3);
        chk_bit(sink, 1'b0);
        sense.supply_ok = 1'b1;
        tick(3);
        chk_bit(sink, 1'b1);
        // Rise to 9 V, a short glitch, a hold request, then 12 V
        walk_on = 1'b1;
        ask_for(REQ_9V, REQ_9V);
        wait_sp(SP_9V);
        chk_sp(sp, SP_9V);
        ask = REQ_12V;
        tick(DEB - 2);
        ask_for(REQ_9V, REQ_9V);
        ask_for(REQ_HOLD, REQ_9V);
        ask_for(REQ_12V, REQ_12V);
        wait_sp(SP_12V);
        chk_sp(sp, SP_12V);
        // Lowering keeps discharge on until feedback has dropped for the tail
        sense.converter_feedback_node = 1'b1;
        ask_for(REQ_9V, REQ_9V);
        tick(2);
        chk_bit(guard, 1'b1);
        wait_sp(SP_9V);
        tick(DIS + 4);
        chk_bit(guard, 1'b1);
        sense.converter_feedback_node = 1'b0;
        tick(DIS - 2);
        chk_bit(guard, 1'b1);
        tick(6);
        chk_bit(guard, 1'b0);
        // Overvoltage at 9 V: trip just above 115 percent, recover below 5.5 V
        walk_on = 1'b0;
        sense.vin_code = 8'h67;
        tick(3);
        chk_bit(guard, 1'b0);
        sense.vin_code = 8'h68;
        tick(3);
        chk_bit(guard, 1'b1);
        sense.vin_code = 8'h37;
        tick(3);
        chk_bit(guard, 1'b1);
        sense.vin_code = 8'h36;
        tick(3);
        chk_bit(guard, 1'b0);
        chk_mode(mode, REQ_5V);
        chk_sp(sp, SP_DEF);
        sense.vin_code = 8'h20 + 8'($random(seed) & 15);
        plug = 1'b0;
        tick(3);
        // Unplug from 12 V walks back to the default
        walk_on = 1'b1;
        ask_for(REQ_12V, REQ_12V);
        wait_sp(SP_12V);
        plug = 1'b0;
        tick(3);
        chk_mode(mode, REQ_5V);
        chk_bit(guard, 1'b1);
        wait_sp(SP_DEF);
        chk_sp(sp, SP_DEF);
        tick(DIS + 4);
        chk_bit(guard, 1'b0);
        // Continuous steps, down to the floor, up to the ceiling, then random
        ask_for(REQ_CONT, REQ_CONT);
        exp_sp = SP_DEF;
        for (int i = 0; i < 90; i++) begin
            up = (i < 20) ? 1'b0 : (i < 70) ? 1'b1 : 1'($random(seed));
            inc = up;
            dec = ~up;
            tick(1);
            inc = 1'b0;
            dec = 1'b0;
            exp_sp = cont_next(exp_sp, up);
            tick(2 * STP + 1);
            chk_sp(sp, exp_sp);
        end
        // Fixed 5 V request walks the setpoint back to the default
        ask_for(REQ_5V, REQ_5V);
        wait_sp(SP_DEF);
        chk_sp(sp, SP_DEF);
        // Thermal shutdown with hysteresis
        walk_on = 1'b0;
        sense.temp_code = 8'hA0;
        tick(3);
        chk_bit(shut, 1'b0);
        sense.temp_code = 8'hA1;
        tick(3);
        chk_bit(shut, 1'b1);
        chk_bit(sink, 1'b0);
        sense.temp_code = 8'h7D;
        tick(3);
        chk_bit(shut, 1'b1);
        sense.temp_code = 8'h7C;
        tick(3);
        chk_bit(shut, 1'b0);
        // Enable low stops the block and restores the default setpoint
        i_en = 1'b0;
        tick(3);
        chk_bit(shut, 1'b1);
        chk_sp(sp, SP_DEF);
        i_en = 1'b1;
        tick(3);
        chk_bit(shut, 1'b0);
        print_verdict();
    end
endmodule
